//--- pkg/bitgrp_pkg.sv
`default_nettype none

package bitgrp_pkg;

   // ==========================================================
   // Opcode field positions and values
   // ==========================================================
   localparam logic [3:0]  GROUP_CODE     = 4'h0;    // Bits 15:12 of this group
   localparam logic [2:0]  MOVE_EA_MODE   = 3'h1;    // Bits 5:3 mark the byte move
   localparam logic [2:0]  SEL_W_IN       = 3'h4;    // Word, memory to register
   localparam logic [2:0]  SEL_L_IN       = 3'h5;    // Long, memory to register
   localparam logic [2:0]  SEL_W_OUT      = 3'h6;    // Word, register to memory
   localparam logic [2:0]  SEL_L_OUT      = 3'h7;    // Long, register to memory
   localparam logic [2:0]  IMM_OR_CODE    = 3'h0;    // Bits 11:9 values
   localparam logic [2:0]  IMM_AND_CODE   = 3'h1;
   localparam logic [2:0]  IMM_SUB_CODE   = 3'h2;
   localparam logic [2:0]  IMM_ADD_CODE   = 3'h3;
   localparam logic [15:0] CCR_TAIL       = 16'h003C; // Low bits of condition byte form
   localparam logic [15:0] SR_TAIL        = 16'h007C; // Low bits of status word form
   localparam logic [15:0] TARGET_MASK    = 16'hF1FF; // Ignores bits 11:9
   localparam logic [1:0]  SZ_BYTE        = 2'h0;
   localparam logic [1:0]  SZ_WORD        = 2'h1;
   localparam logic [1:0]  SZ_LONG        = 2'h2;
   localparam logic [1:0]  BIT_TEST_CODE  = 2'h0;    // Bits 7:6 of dynamic bit forms
   localparam logic [1:0]  BIT_CHG_CODE   = 2'h1;
   localparam logic [1:0]  BIT_CLR_CODE   = 2'h2;
   localparam logic [1:0]  BOUNDS_CODE    = 2'h3;    // Bits 7:6 of bounds forms
   localparam int          CHECK_BIT      = 11;      // Extension word: check vs compare
   localparam int          KIND_BIT       = 15;      // Extension word: address vs data
   localparam logic [1:0]  EXT_NONE       = 2'h0;
   localparam logic [1:0]  EXT_ONE        = 2'h1;
   localparam logic [1:0]  EXT_TWO        = 2'h2;

   // ==========================================================
   // Types
   // ==========================================================
   typedef enum logic [1:0] {SIZE_BYTE, SIZE_WORD, SIZE_LONG, SIZE_NONE} size_t;

   typedef enum logic [4:0] {
      OP_NONE, immediate_or, immediate_and, immediate_subtract, immediate_add,
      or_condition_code_byte, or_status_word, and_condition_code_byte,
      and_status_word, bounds_compare, bounds_check, bit_test, bit_change,
      bit_clear, bit_set, peripheral_byte_move
   } op_t;

   typedef struct packed {
      op_t        op;          // Decoded operation
      size_t      size;        // Operand size
      logic [2:0] data_reg;    // Data register (bit and move forms)
      logic [2:0] ea_mode;     // Effective address mode field
      logic [2:0] ea_reg;      // Effective address register field
      logic       to_memory;   // Move direction, register out to memory
      logic       bounds_addr; // Bounds register is an address register
      logic [2:0] bounds_reg;  // Bounds register number
      logic [1:0] ext_count;   // Extension words still owed to execution
      logic       illegal;     // Pattern not handled by this group
   } decode_t;

endpackage : bitgrp_pkg

`default_nettype wire

//--- hdl/size_field_decoder.sv
`timescale 1ns/1ns
`default_nettype none

// ============================================================
// Two-bit operand size field to size type
// ============================================================
module size_field_decoder
   import bitgrp_pkg::*;
(
   input  wire logic [1:0] field,   // Raw size field
   output logic            valid,   // Field names a real size
   output size_t           size     // Decoded size
);

   // Pattern 11 is not a size; caller flags it illegal
   always_comb begin
      valid = 1'b1;
      if (field == SZ_BYTE) begin
         size = SIZE_BYTE;
      end else if (field == SZ_WORD) begin
         size = SIZE_WORD;
      end else if (field == SZ_LONG) begin
         size = SIZE_LONG;
      end else begin
         size  = SIZE_NONE;
         valid = 1'b0;
      end
   end

endmodule : size_field_decoder

`default_nettype wire

//--- hdl/immediate_bit_group_decoder.sv
`timescale 1ns/1ns
`default_nettype none

// ============================================================
// First-word decoder for opcode group 0000
// ============================================================
module immediate_bit_group_decoder
   import bitgrp_pkg::*;
(
   input  wire logic        ref_clk,    // Processor clock
   input  wire logic        resetn,     // Asynchronous reset, active low
   input  wire logic        word_valid, // Fetch offers a word this cycle
   input  wire logic [15:0] word_data,  // Opcode or extension word
   output logic             ext_wait,   // Next word taken is a bounds extension
   output logic             dec_valid,  // One-cycle pulse, decode stands in dec
   output decode_t          dec         // Decoded instruction
);

   // ==========================================================
   // State
   // ==========================================================
   typedef enum logic {ST_FIRST, ST_EXT} state_t;

   state_t     st_r, st_nxt;         // Waiting for opcode or for extension
   decode_t    dec_r, dec_nxt;       // Registered decode
   logic       dv_r, dv_nxt;         // Registered decode pulse
   decode_t    hold_r, hold_nxt;     // Bounds decode parked for its extension
   logic       imm_ok;               // Immediate size field is legal
   size_t      imm_size;             // Immediate size
   logic       bnd_ok;               // Bounds size field is legal
   size_t      bnd_size;             // Bounds size
   logic       first_take;           // Opcode word accepted
   logic       ext_take;             // Extension word accepted

   assign first_take = word_valid && (st_r == ST_FIRST);
   assign ext_take   = word_valid && (st_r == ST_EXT);
   assign ext_wait   = (st_r == ST_EXT);
   assign dec_valid  = dv_r;
   assign dec        = dec_r;

   // Immediate forms keep size in bits 7:6
   size_field_decoder u_imm_size (
      .field (word_data[7:6]),
      .valid (imm_ok),
      .size  (imm_size)
   );

   // Bounds forms keep size in bits 10:9
   size_field_decoder u_bnd_size (
      .field (word_data[10:9]),
      .valid (bnd_ok),
      .size  (bnd_size)
   );

   // Extension words owed after the opcode for an immediate operand
   function automatic logic [1:0] imm_words(input size_t s);
      if (s == SIZE_LONG) begin
         return EXT_TWO;
      end else begin
         return EXT_ONE;
      end
   endfunction : imm_words

   // ==========================================================
   // Next-state and decode logic
   // ==========================================================
   always_comb begin
      decode_t d;
      d        = '0;
      st_nxt   = st_r;
      dv_nxt   = 1'b0;
      dec_nxt  = dec_r;
      hold_nxt = hold_r;
      d.op          = OP_NONE;
      d.size        = SIZE_NONE;
      d.data_reg    = word_data[11:9];
      d.ea_mode     = word_data[5:3];
      d.ea_reg      = word_data[2:0];
      case (st_r)
         ST_FIRST: begin
            if (first_take) begin
               dv_nxt = 1'b1;
               if (word_data[15:12] != GROUP_CODE) begin
                  // Other groups are not ours
                  d.illegal = 1'b1;
               end else if (word_data[8]) begin
                  if (word_data[5:3] == MOVE_EA_MODE) begin
                     d.op        = peripheral_byte_move;
                     d.ext_count = EXT_ONE;  // Displacement follows
                     d.to_memory = word_data[7];
                     if (word_data[8:6] == SEL_W_IN) begin
                        d.size = SIZE_WORD;
                     end else if (word_data[8:6] == SEL_L_IN) begin
                        d.size = SIZE_LONG;
                     end else if (word_data[8:6] == SEL_W_OUT) begin
                        d.size = SIZE_WORD;
                     end else begin
                        // Remaining selector 111 is the long outbound form
                        d.size = SIZE_LONG;
                     end
                  end else begin
                     // Bit number comes from the data register
                     d.size = SIZE_NONE;
                     case (word_data[7:6])
                        BIT_TEST_CODE: d.op = bit_test;
                        BIT_CHG_CODE:  d.op = bit_change;
                        BIT_CLR_CODE:  d.op = bit_clear;
                        default:       d.op = bit_set;
                     endcase
                  end
               end else if (!word_data[11] && word_data[7:6] == BOUNDS_CODE) begin
                  // Bounds forms: decode finishes on the extension word unless size is 11
                  d.size    = bnd_size;
                  d.illegal = !bnd_ok;
                  d.op      = bounds_compare;
                  if (bnd_ok) begin
                     dv_nxt   = 1'b0;
                     hold_nxt = d;
                     st_nxt   = ST_EXT;
                  end
               end else if ((word_data[11:9] == IMM_OR_CODE)
                            || (word_data[11:9] == IMM_AND_CODE)) begin
                  d.ext_count = EXT_ONE;
                  if ((word_data & TARGET_MASK) == CCR_TAIL) begin
                     d.size = SIZE_BYTE;
                     d.op   = word_data[9] ? and_condition_code_byte
                                           : or_condition_code_byte;
                  end else if ((word_data & TARGET_MASK) == SR_TAIL) begin
                     d.size = SIZE_WORD;
                     d.op   = word_data[9] ? and_status_word : or_status_word;
                  end else begin
                     d.size      = imm_size;
                     d.illegal   = !imm_ok;
                     d.ext_count = imm_words(imm_size);
                     d.op        = word_data[9] ? immediate_and : immediate_or;
                  end
               end else if ((word_data[11:9] == IMM_SUB_CODE)
                            || (word_data[11:9] == IMM_ADD_CODE)) begin
                  d.size      = imm_size;
                  d.illegal   = !imm_ok;
                  d.ext_count = imm_words(imm_size);
                  d.op        = word_data[9] ? immediate_add : immediate_subtract;
               end else begin
                  // Remaining static forms belong to another decoder
                  d.illegal = 1'b1;
               end
               if (dv_nxt) begin
                  dec_nxt = d;
               end
            end
         end
         ST_EXT: begin
            if (ext_take) begin
               // Extension picks check or compare and the bounds register
               dec_nxt             = hold_r;
               dec_nxt.op          = word_data[CHECK_BIT] ? bounds_check : bounds_compare;
               dec_nxt.bounds_addr = word_data[KIND_BIT];
               dec_nxt.bounds_reg  = word_data[14:12];
               dv_nxt              = 1'b1;
               st_nxt              = ST_FIRST;
            end
         end
         default: st_nxt = ST_FIRST;
      endcase
   end

   // Registers only; no reset value depends on a port
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         st_r   <= ST_FIRST;
         dec_r  <= '0;
         dv_r   <= 1'b0;
         hold_r <= '0;
      end else begin
         st_r   <= st_nxt;
         dec_r  <= dec_nxt;
         dv_r   <= dv_nxt;
         hold_r <= hold_nxt;
      end
   end

   // ==========================================================
   // Checks
   // ==========================================================
   sequence s_move_first(logic [2:0] sel);
      first_take && word_data[15:12] == GROUP_CODE && word_data[8:6] == sel
         && word_data[5:3] == MOVE_EA_MODE;
   endsequence

   sequence s_bounds_first;
      first_take && word_data[15:12] == GROUP_CODE && !word_data[11] && !word_data[8]
         && word_data[7:6] == BOUNDS_CODE && word_data[10:9] != BOUNDS_CODE;
   endsequence

   chk_size_byte: assert property (@(posedge ref_clk) disable iff (!resetn)
      first_take && word_data[15:9] == 7'h03 && word_data[8:6] == 3'h0
         && word_data[5:0] != 6'h3C |=> dv_r && dec_r.op == immediate_add
         && dec_r.size == SIZE_BYTE && dec_r.ext_count == EXT_ONE)
      else $error("byte immediate add misdecoded");

   chk_size_long: assert property (@(posedge ref_clk) disable iff (!resetn)
      first_take && word_data[15:9] == 7'h02 && word_data[8:6] == 3'h2
         |=> dv_r && dec_r.size == SIZE_LONG && dec_r.ext_count == EXT_TWO)
      else $error("long immediate size misdecoded");

   chk_move_word_in: assert property (@(posedge ref_clk) disable iff (!resetn)
      s_move_first(SEL_W_IN) |=> dv_r && dec_r.op == peripheral_byte_move
         && dec_r.size == SIZE_WORD && !dec_r.to_memory)
      else $error("word inbound move misdecoded");

   chk_move_long_in: assert property (@(posedge ref_clk) disable iff (!resetn)
      s_move_first(SEL_L_IN) |=> dv_r && dec_r.size == SIZE_LONG && !dec_r.to_memory)
      else $error("long inbound move misdecoded");

   chk_move_word_out: assert property (@(posedge ref_clk) disable iff (!resetn)
      s_move_first(SEL_W_OUT) |=> dv_r && dec_r.size == SIZE_WORD && dec_r.to_memory)
      else $error("word outbound move misdecoded");

   chk_move_long_out: assert property (@(posedge ref_clk) disable iff (!resetn)
      s_move_first(SEL_L_OUT) |=> dv_r && dec_r.size == SIZE_LONG && dec_r.to_memory)
      else $error("long outbound move misdecoded");

   chk_status_target: assert property (@(posedge ref_clk) disable iff (!resetn)
      first_take && word_data == SR_TAIL |=> dv_r && dec_r.op == or_status_word
         && dec_r.size == SIZE_WORD)
      else $error("status word target misdecoded");

   // Opcode taken, no answer yet, extension owed
   sequence s_ext_owed;
      !dv_r && ext_wait;
   endsequence

   // Extension word taken and it asks for the trapping check
   sequence s_ext_check;
      ext_take && word_data[CHECK_BIT];
   endsequence

   // Extension word taken and it asks for the plain compare
   sequence s_ext_compare;
      ext_take && !word_data[CHECK_BIT];
   endsequence

   // Answer that closes a bounds pair
   sequence s_bounds_done;
      dv_r && !ext_wait && dec_r.size != SIZE_NONE;
   endsequence

   chk_bounds_wait: assert property (@(posedge ref_clk) disable iff (!resetn)
      s_bounds_first |=> s_ext_owed)
      else $error("bounds opcode did not wait for its extension");

   chk_bounds_ext: assert property (@(posedge ref_clk) disable iff (!resetn)
      s_ext_check |=> s_bounds_done and (dec_r.op == bounds_check))
      else $error("bounds check extension misdecoded");

   chk_bounds_cmp: assert property (@(posedge ref_clk) disable iff (!resetn)
      s_ext_compare |=> s_bounds_done and (dec_r.op == bounds_compare))
      else $error("bounds compare extension misdecoded");

endmodule : immediate_bit_group_decoder

`default_nettype wire

//--- sim/fetch_model.sv
`timescale 1ns/1ns
`default_nettype none

// ============================================================
// Fetch stage stand-in: offers opcode and extension words
// ============================================================
module fetch_model (
   input  wire logic        ref_clk,     // Processor clock
   output logic             word_valid,  // A word is offered this cycle
   output logic [15:0]      word_data    // Offered word
);
   // Idle at time zero so the decoder never sees a floating request
   initial begin
      word_valid = 1'h0;
      word_data  = 16'h0000;
   end

   // Offer one word at the current edge; it is taken at the next edge.
   // A gap of zero keeps valid high, so words go back to back.
   task offer(input logic [15:0] w, input int gap);
      word_valid <= 1'h1;
      word_data  <= w;
      @(posedge ref_clk);
      if (gap > 0) begin
         // Released bus shows the inverse, so stale data cannot pass for good
         word_valid <= 1'h0;
         word_data  <= ~w;
      end
      repeat (gap) @(posedge ref_clk);
   endtask : offer

   // Drop the request after a back-to-back burst
   task idle;
      word_valid <= 1'h0;
      word_data  <= ~word_data;
   endtask : idle
endmodule : fetch_model

`default_nettype wire

//--- sim/immediate_bit_group_decoder_bench.sv
`timescale 1ns/1ns
`default_nettype none

// ============================================================
// Self-checking bench: expected decodes queued, monitor compares
// ============================================================
module immediate_bit_group_decoder_bench;
   import bitgrp_pkg::*;

   typedef struct packed {
      op_t        op;   // Expected operation
      size_t      size; // Expected size
      logic       ill;  // Expected illegal flag
      logic [3:0] key;  // Form-specific field
      logic [5:0] ea;   // Expected mode and register fields
   } note_t;

   logic        ref_clk;    // 50 ns clock
   logic        resetn;     // Active low reset
   logic        word_valid; // From fetch model
   logic [15:0] word_data;  // From fetch model
   logic        ext_wait;   // Decoder awaits bounds extension
   logic        dec_valid;  // Decode pulse
   decode_t     dec;        // Decoded fields
   logic        ext_exp;    // Expected ext_wait at the next taken word
   note_t       notes[$];   // Expected decodes, oldest first
   note_t       got_note;   // Note being compared
   int          failures;   // Mismatches
   int          compares;   // Comparisons made
   integer      seed;       // Random seed
   logic [15:0] w;          // Word being built
   logic [5:0]  ea;         // Random effective address field
   logic [2:0]  d;          // Random register number

   fetch_model fetch_u (.ref_clk(ref_clk), .word_valid(word_valid), .word_data(word_data));

   immediate_bit_group_decoder dut_u (
      .ref_clk(ref_clk), .resetn(resetn), .word_valid(word_valid), .word_data(word_data),
      .ext_wait(ext_wait), .dec_valid(dec_valid), .dec(dec));

   initial begin
      ref_clk = 1'h0;
      forever #25 ref_clk = ~ref_clk;
   end

   // ==========================================================
   // Helpers
   // ==========================================================
   task check(input string what, input logic [7:0] exp, input logic [7:0] got);
      compares++;
      if (got !== exp) begin
         failures++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask : check

   task finish_test;
      if (notes.size() != 0) failures++;
      $display("failures %0d compares %0d", failures, compares);
      if (failures == 0 && compares > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask : finish_test

   task note(input op_t op, input size_t sz, input logic ill, input logic [3:0] key,
             input logic [5:0] ea_e);
      notes.push_back('{op, sz, ill, key, ea_e});
   endtask : note

   // Random gap of 0..2 cycles exercises both prompt and slow fetch
   task send(input logic [15:0] wd);
      fetch_u.offer(wd, $unsigned($random(seed)) % 3);
   endtask : send

   // Field of interest depends on the form; unused fields have no fixed value
   function automatic logic [3:0] key_of(input op_t op, input decode_t dd);
      case (op)
         peripheral_byte_move:                     key_of = {dd.to_memory, dd.data_reg};
         bit_test, bit_change, bit_clear, bit_set: key_of = {1'h0, dd.data_reg};
         bounds_compare, bounds_check:             key_of = {dd.bounds_addr, dd.bounds_reg};
         default:                                  key_of = {2'h0, dd.ext_count};
      endcase
   endfunction : key_of

   // Random EA that avoids mode 001 (byte move) and mode 111 (special tails)
   task pick_ea;
      ea = 6'($random(seed));
      if (ea[5:3] == 3'h1 || ea[5:3] == 3'h7) ea[5:3] = 3'h2;
      d = 3'($random(seed));
   endtask : pick_ea

   // ==========================================================
   // Monitor: ext_wait at every taken word, decode at every pulse
   // ==========================================================
   // Skipped while reset is low: at the very first edge the decode flops may still be unknown
   always @(posedge ref_clk) begin
      if (resetn === 1'h1) begin
         if (word_valid === 1'h1) check("ext_wait", {7'h0, ext_exp}, {7'h0, ext_wait});
         if (dec_valid !== 1'h0) begin
            if (notes.size() == 0) check("dec_valid", 8'h00, {7'h0, dec_valid});
            else begin
               got_note = notes.pop_front();
               check("illegal", {7'h0, got_note.ill}, {7'h0, dec.illegal});
               if (!got_note.ill) begin
                  check("op", {3'h0, got_note.op}, {3'h0, dec.op});
                  check("size", {6'h0, got_note.size}, {6'h0, dec.size});
                  check("key", {4'h0, got_note.key}, {4'h0, key_of(got_note.op, dec)});
                  check("ea", {2'h0, got_note.ea}, {2'h0, dec.ea_mode, dec.ea_reg});
               end
            end
         end
      end
   end

   // Hang guard
   initial begin
      repeat (5000) @(posedge ref_clk);
      failures++;
      finish_test();
   end

   // ==========================================================
   // Scenarios
   // ==========================================================
   initial begin
      seed     = 94;
      failures = 0;
      compares = 0;
      ext_exp  = 1'h0;
      resetn   = 1'h0;
      repeat (4) @(posedge ref_clk);
      resetn <= 1'h1;
      @(posedge ref_clk);
      // Immediate forms, every code and size, back to back at random
      for (int c = 0; c < 4; c++) begin
         for (int s = 0; s < 3; s++) begin
            pick_ea();
            note(op_t'(c + 1), size_t'(s), 1'h0,
                 (s == 2) ? {2'h0, EXT_TWO} : {2'h0, EXT_ONE}, ea);
            send({4'h0, 3'(c), 1'h0, 2'(s), ea});
         end
      end
      // Condition byte and status word targets of OR and AND
      for (int k = 0; k < 4; k++) begin
         w = 16'h003C | (k[0] ? 16'h0040 : 16'h0000) | (k[1] ? 16'h0200 : 16'h0000);
         note(op_t'(5 + k), k[0] ? SIZE_WORD : SIZE_BYTE, 1'h0, {2'h0, EXT_ONE}, 6'h3C);
         send(w);
      end
      // Peripheral byte move, all four selectors
      for (int sel = 4; sel < 8; sel++) begin
         pick_ea();
         note(peripheral_byte_move, sel[0] ? SIZE_LONG : SIZE_WORD, 1'h0, {sel[1], d},
              {MOVE_EA_MODE, ea[2:0]});
         send({4'h0, d, 3'(sel), 3'h1, ea[2:0]});
      end
      // Dynamic bit forms
      for (int t = 0; t < 4; t++) begin
         pick_ea();
         note(op_t'(11 + t), SIZE_NONE, 1'h0, {1'h0, d}, ea);
         send({4'h0, d, 1'h1, 2'(t), ea});
      end
      // Bounds forms, both kinds, every size; size 11 is refused at once
      for (int c = 0; c < 4; c++) begin
         for (int chk = 0; chk < 2; chk++) begin
            pick_ea();
            w = {4'h0, 1'h0, 2'(c), 3'h3, 6'h10};
            if (c == 3) begin
               note(OP_NONE, SIZE_NONE, 1'h1, 4'h0, 6'h00);
               send(w);
            end else begin
               note(chk ? bounds_check : bounds_compare, size_t'(c), 1'h0, {ea[0], d},
                    w[5:0]);
               send(w);
               ext_exp <= 1'h1;
               send({ea[0], d, 1'(chk), 11'h000});
               ext_exp <= 1'h0;
            end
         end
      end
      // Word outside the group
      note(OP_NONE, SIZE_NONE, 1'h1, 4'h0, 6'h00);
      send(16'h4E71);
      // Static compare-immediate pattern belongs to another decoder
      note(OP_NONE, SIZE_NONE, 1'h1, 4'h0, 6'h00);
      send(16'h0C40);
      // Reset while a bounds extension is owed; next word is a fresh opcode
      fetch_u.offer(16'h04D0, 1);
      resetn <= 1'h0;
      @(posedge ref_clk);
      check("ext_wait_reset", 8'h00, {7'h0, ext_wait});
      resetn <= 1'h1;
      @(posedge ref_clk);
      note(immediate_add, SIZE_LONG, 1'h0, {2'h0, EXT_TWO}, 6'h00);
      send(16'h0680);
      fetch_u.idle();
      repeat (4) @(posedge ref_clk);
      finish_test();
   end
endmodule : immediate_bit_group_decoder_bench

`default_nettype wire
